/* File: logic/irf_pkg.sv */
// Constants, types and register map of the configuration frame
package irf_pkg;

    // Bus widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int SPACE_W = 2;

    // Frame geometry: 64K window, 64KB aligned
    localparam int FRAME_BITS = 16;
    localparam int IMP_WORDS = 64;
    localparam logic [7:0] IMP_PAGE = 8'h0E;

    // Register offsets inside the frame
    localparam logic [11:0] OFS_ID0 = 12'h000;
    localparam logic [11:0] OFS_ID1 = 12'h004;
    localparam logic [11:0] OFS_ID2 = 12'h008;
    localparam logic [11:0] OFS_ID3 = 12'h00C;
    localparam logic [11:0] OFS_ID4 = 12'h010;
    localparam logic [11:0] OFS_ID5 = 12'h014;
    localparam logic [11:0] OFS_ID6 = 12'h018;
    localparam logic [11:0] OFS_ID7 = 12'h01C;
    localparam logic [11:0] OFS_IMPL_ID = 12'h040;
    localparam logic [11:0] OFS_ARCH_ID = 12'h044;
    localparam logic [11:0] OFS_CTRL0 = 12'h080;
    localparam logic [11:0] OFS_CTRL1 = 12'h084;
    localparam logic [11:0] OFS_SYNC_REQ = 12'h0C0;
    localparam logic [11:0] OFS_SYNC_STAT = 12'h0C4;
    localparam logic [11:0] OFS_SH_VM = 12'h100;
    localparam logic [11:0] OFS_SH_SEL = 12'h108;
    localparam logic [11:0] OFS_SH_DOM = 12'h10C;
    localparam logic [11:0] OFS_SH_RESAMPLE = 12'h110;
    localparam logic [11:0] OFS_SH_CFG = 12'h114;
    localparam logic [11:0] OFS_SH_STAT = 12'h118;
    localparam logic [11:0] OFS_CORE_SEL = 12'h140;
    localparam logic [11:0] OFS_CORE_STAT = 12'h144;
    localparam logic [11:0] OFS_CORE_CTRL = 12'h148;
    localparam logic [11:0] OFS_ST_BASE = 12'h180;
    localparam logic [11:0] OFS_ST_CFG = 12'h190;
    localparam logic [11:0] OFS_ST_STAT = 12'h194;
    localparam logic [11:0] OFS_ST_L2MAP = 12'h1C0;
    localparam logic [11:0] OFS_VMT_BASE = 12'h200;
    localparam logic [11:0] OFS_VMT_CFG = 12'h210;
    localparam logic [11:0] OFS_VMT_STAT = 12'h214;
    localparam logic [11:0] OFS_VC_SEL = 12'h240;
    localparam logic [11:0] OFS_VC_DB = 12'h248;
    localparam logic [11:0] OFS_VC_TOP = 12'h250;
    localparam logic [11:0] OFS_VC_CTRL = 12'h258;
    localparam logic [11:0] OFS_VC_STAT = 12'h25C;
    localparam logic [11:0] OFS_VM_DB = 12'h280;
    localparam logic [11:0] OFS_VM_SEL = 12'h288;
    localparam logic [11:0] OFS_VM_STAT = 12'h28C;
    localparam logic [11:0] OFS_MAP_VMT_L2 = 12'h2C0;
    localparam logic [11:0] OFS_MAP_VM = 12'h2C8;
    localparam logic [11:0] OFS_MAP_VST = 12'h2D0;
    localparam logic [11:0] OFS_MAP_VST_L2 = 12'h2D8;
    localparam logic [11:0] OFS_MAP_VC = 12'h2E0;
    localparam logic [11:0] OFS_SAVE_VM = 12'h300;
    localparam logic [11:0] OFS_SAVE_STAT = 12'h308;
    localparam logic [11:0] OFS_MEM_ENC_ID = 12'h340;
    localparam logic [11:0] OFS_MEM_ENC_CTX = 12'h344;
    localparam logic [11:0] OFS_PART_MON_ID = 12'h380;
    localparam logic [11:0] OFS_HI_WORD = 12'h004;

    // Field positions and reset values
    localparam int CTRL0_EN_BIT = 0;
    localparam int CTRL0_IDLE_BIT = 1;
    localparam int ID0_INJ_BIT = 0;
    localparam logic CTRL0_EN_RST = 1'b0;
    localparam logic CTRL0_IDLE_RST = 1'b1;
    localparam logic [DATA_W-1:0] CTRL1_MASK = 32'h0000_FFFF;

    // Enable transition settle time
    localparam int CLK_PERIOD_NS = 10;
    localparam int ENABLE_TIME_NS = 40;
    localparam int ENABLE_CYCLES = (ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {K_NONE, K_RO, K_RW, K_WO, K_IMP} irf_kind_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [SPACE_W-1:0] space;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] strb;
    } irf_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [DATA_W-1:0] rdata;
    } irf_rsp_t;

endpackage : irf_pkg

/* File: logic/irf_config_frame.sv */
// Configuration register frame of one interrupt domain of a routing service
`timescale 1ns/1ps
// Behaviour
// - Reads and writes complete strictly in the order in which they arrive, never reordered.
// - Each interrupt domain has a configuration frame and optionally an injection frame, each a 64K window.
// - When the injection frame present flag reads 0 the injection frame is not implemented at all.
// - Register dependencies always resolve within this same domain's frame on this same routing service.
// - The frame base sits on a 64KB boundary and differs from every other frame base.
// - Offsets in the window that hit no register read as zero and ignore writes.
// - The frame answers its own domain's address space, and optionally the management root space.
// - Sixty-four word slots from offset 0x0E00 are reserved with implementation-defined access.
module irf_config_frame
    import irf_pkg::*;
#(
    parameter logic [ADDR_W-1:0] CFG_BASE = 32'h0001_0000,
    parameter logic [ADDR_W-1:0] INJ_BASE = 32'h0002_0000,
    parameter bit INJ_PRESENT = 1'b1,
    parameter logic [SPACE_W-1:0] DOMAIN_SPACE = 2'h0,
    parameter logic [SPACE_W-1:0] MGMT_SPACE = 2'h3,
    parameter bit MGMT_ACCESS = 1'b0,
    // Identity values below are arbitrary
    parameter logic [DATA_W-1:0] ID0_VALUE = 32'h0000_0000,
    parameter logic [DATA_W-1:0] IMPL_ID_VALUE = 32'h0000_1234,
    parameter logic [DATA_W-1:0] ARCH_ID_VALUE = 32'h0000_0000
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register access
    input wire irf_req_t req_i,
    output irf_rsp_t rsp_o,
    // Domain control
    output logic enable_o,
    output logic idle_o
);

    // Base alignment and distinct frames
    initial begin
        if (CFG_BASE[FRAME_BITS-1:0] != '0) begin
            $error("configuration frame base not 64KB aligned");
        end
        if (INJ_PRESENT && INJ_BASE[FRAME_BITS-1:0] != '0) begin
            $error("injection frame base not 64KB aligned");
        end
        if (INJ_PRESENT && INJ_BASE[ADDR_W-1:FRAME_BITS] == CFG_BASE[ADDR_W-1:FRAME_BITS]) begin
            $error("injection frame base equals configuration frame base");
        end
        if (MGMT_ACCESS && MGMT_SPACE == DOMAIN_SPACE) begin
            $error("management space code equals domain space code");
        end
    end

    function automatic irf_kind_t word_kind(input logic [FRAME_BITS-1:0] ofs);
        irf_kind_t k;
        k = K_NONE;
        if (ofs[FRAME_BITS-1:8] == IMP_PAGE) begin
            k = K_IMP;
        end else if (ofs[FRAME_BITS-1:12] == 4'h0) begin
            case (ofs[11:0])
                OFS_ID0, OFS_ID1, OFS_ID2, OFS_ID3,
                OFS_ID4, OFS_ID5, OFS_ID6, OFS_ID7,
                OFS_IMPL_ID, OFS_ARCH_ID, OFS_SYNC_STAT, OFS_SH_STAT,
                OFS_CORE_STAT, OFS_ST_STAT, OFS_VMT_STAT,
                OFS_VC_TOP, OFS_VC_TOP + OFS_HI_WORD,
                OFS_VC_STAT, OFS_VM_STAT, OFS_SAVE_STAT,
                OFS_MEM_ENC_ID, OFS_PART_MON_ID: k = K_RO;
                OFS_SYNC_REQ, OFS_SH_SEL, OFS_SH_RESAMPLE,
                OFS_CORE_SEL, OFS_ST_L2MAP, OFS_VM_SEL: k = K_WO;
                OFS_CTRL0, OFS_CTRL1, OFS_SH_DOM, OFS_SH_CFG,
                OFS_CORE_CTRL, OFS_ST_CFG, OFS_VMT_CFG, OFS_VC_CTRL,
                OFS_MEM_ENC_CTX,
                OFS_SH_VM, OFS_SH_VM + OFS_HI_WORD,
                OFS_ST_BASE, OFS_ST_BASE + OFS_HI_WORD,
                OFS_VMT_BASE, OFS_VMT_BASE + OFS_HI_WORD,
                OFS_VC_SEL, OFS_VC_SEL + OFS_HI_WORD,
                OFS_VC_DB, OFS_VC_DB + OFS_HI_WORD,
                OFS_VM_DB, OFS_VM_DB + OFS_HI_WORD,
                OFS_MAP_VMT_L2, OFS_MAP_VMT_L2 + OFS_HI_WORD,
                OFS_MAP_VM, OFS_MAP_VM + OFS_HI_WORD,
                OFS_MAP_VST, OFS_MAP_VST + OFS_HI_WORD,
                OFS_MAP_VST_L2, OFS_MAP_VST_L2 + OFS_HI_WORD,
                OFS_MAP_VC, OFS_MAP_VC + OFS_HI_WORD,
                OFS_SAVE_VM, OFS_SAVE_VM + OFS_HI_WORD: k = K_RW;
                default: k = K_NONE;
            endcase
        end
        return k;
    endfunction : word_kind

    function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
                                                      input logic [DATA_W-1:0] new_v,
                                                      input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] m;
        m = old_v;
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b]) begin
                m[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return m;
    endfunction : merge_bytes

    // Decode of the incoming access
    logic space_ok;
    logic in_cfg;
    logic in_inj;
    logic claim;
    logic [FRAME_BITS-1:0] ofs;
    irf_kind_t kind;
    logic do_write;
    logic do_read;

    // Only this domain's space, management space when allowed
    assign space_ok = (req_i.space == DOMAIN_SPACE) || (MGMT_ACCESS && req_i.space == MGMT_SPACE);
    // Whole 64K window claimed, only upper bits compared
    assign in_cfg = req_i.addr[ADDR_W-1:FRAME_BITS] == CFG_BASE[ADDR_W-1:FRAME_BITS];
    // Absent injection frame claims nothing
    assign in_inj = INJ_PRESENT && req_i.addr[ADDR_W-1:FRAME_BITS] == INJ_BASE[ADDR_W-1:FRAME_BITS];
    assign claim = req_i.valid && space_ok && (in_cfg || in_inj);
    assign ofs = req_i.addr[FRAME_BITS-1:0];
    // Injection frame contents live elsewhere, so here it reads as zero
    assign kind = in_cfg ? word_kind(ofs) : K_NONE;
    assign do_write = claim && req_i.write;
    assign do_read = claim && !req_i.write;

    // Register storage, local to this domain's frame only
    logic [DATA_W-1:0] regs_r [0:255];
    logic [DATA_W-1:0] imp_r [0:IMP_WORDS-1];

    // Plain storage words; write-only words are kept for the block that consumes them
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 256; i++) begin
                regs_r[i] <= 32'h0000_0000;
            end
        end else if (do_write && (kind == K_RW || kind == K_WO) && ofs[11:0] != OFS_CTRL0) begin
            // Read-only words never reach this path
            regs_r[ofs[9:2]] <= merge_bytes(regs_r[ofs[9:2]], req_i.wdata, req_i.strb);
        end
    end

    // Implementation-defined slots behave as plain read/write words
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < IMP_WORDS; i++) begin
                imp_r[i] <= 32'h0000_0000;
            end
        end else if (do_write && kind == K_IMP) begin
            imp_r[ofs[7:2]] <= merge_bytes(imp_r[ofs[7:2]], req_i.wdata, req_i.strb);
        end
    end

    // Enable control with its settle time; enable is frozen while not idle
    logic en_r;
    logic idle_r;
    logic [$clog2(ENABLE_CYCLES+1)-1:0] settle_r;
    logic en_change;

    assign en_change = do_write && kind == K_RW && ofs[11:0] == OFS_CTRL0 && req_i.strb[0]
                       && idle_r && req_i.wdata[CTRL0_EN_BIT] != en_r;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            en_r <= CTRL0_EN_RST;
            idle_r <= CTRL0_IDLE_RST;
            settle_r <= '0;
        end else if (en_change) begin
            en_r <= req_i.wdata[CTRL0_EN_BIT];
            idle_r <= 1'b0;
            settle_r <= ($clog2(ENABLE_CYCLES+1))'(ENABLE_CYCLES - 1);
        end else if (!idle_r) begin
            if (settle_r == '0) begin
                idle_r <= 1'b1;
            end else begin
                settle_r <= settle_r - 1'b1;
            end
        end
    end

    // Read data selection
    logic [DATA_W-1:0] rd_value;

    always_comb begin
        rd_value = 32'h0000_0000;
        case (kind)
            K_RO: begin
                case (ofs[11:0])
                    OFS_ID0: begin
                        rd_value = ID0_VALUE;
                        rd_value[ID0_INJ_BIT] = INJ_PRESENT;
                    end
                    OFS_IMPL_ID: rd_value = IMPL_ID_VALUE;
                    OFS_ARCH_ID: rd_value = ARCH_ID_VALUE;
                    default: rd_value = 32'h0000_0000;
                endcase
            end
            K_RW: begin
                if (ofs[11:0] == OFS_CTRL0) begin
                    rd_value[CTRL0_EN_BIT] = en_r;
                    rd_value[CTRL0_IDLE_BIT] = idle_r;
                end else if (ofs[11:0] == OFS_CTRL1) begin
                    rd_value = regs_r[ofs[9:2]] & CTRL1_MASK;
                end else begin
                    rd_value = regs_r[ofs[9:2]];
                end
            end
            K_IMP: rd_value = imp_r[ofs[7:2]];
            K_WO: rd_value = 32'h0000_0000;
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // One answer per request, one cycle later, in arrival order
    irf_rsp_t rsp_r;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= req_i.valid;
            rsp_r.hit <= claim;
            rsp_r.rdata <= do_read ? rd_value : 32'h0000_0000;
        end
    end

    assign rsp_o = rsp_r;
    assign enable_o = en_r;
    assign idle_o = idle_r;

    // Checks
    answer_order_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        req_i.valid |=> rsp_o.valid && rsp_o.hit == $past(claim))
        else $error("request not answered in the next cycle");

    no_stray_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !req_i.valid |=> !rsp_o.valid && !rsp_o.hit)
        else $error("answer without request");

    window_claim_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        req_i.valid && space_ok && in_cfg |=> rsp_o.hit)
        else $error("access inside frame window not claimed");

    inj_absent_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        req_i.valid && !INJ_PRESENT && !in_cfg
        && req_i.addr[ADDR_W-1:FRAME_BITS] == INJ_BASE[ADDR_W-1:FRAME_BITS] |=> !rsp_o.hit)
        else $error("absent injection frame answered");

    unmapped_zero_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        req_i.valid && !req_i.write && claim && kind == K_NONE |=> rsp_o.hit && rsp_o.rdata == 32'h0000_0000)
        else $error("unmapped offset read nonzero");

    space_gate_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        req_i.valid && !space_ok |=> !rsp_o.hit && rsp_o.rdata == 32'h0000_0000)
        else $error("access from foreign address space claimed");

    imp_slot_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (do_write && kind == K_IMP && req_i.strb == 4'hF)
        ##1 (do_read && kind == K_IMP && req_i.addr == $past(req_i.addr))
        |=> rsp_o.rdata == $past(req_i.wdata, 2))
        else $error("implementation-defined slot lost its value");

    wo_read_zero_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        do_read && kind == K_WO |=> rsp_o.valid && rsp_o.rdata == 32'h0000_0000)
        else $error("write-only register read nonzero");

    enable_settle_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        en_change |=> !idle_o ##ENABLE_CYCLES idle_o)
        else $error("enable transition settle time wrong");

endmodule : irf_config_frame

/* File: bench/irf_pe_model.sv */
// Processing element model issuing single-word accesses to the frame
`timescale 1ns/1ps
module irf_pe_model
    import irf_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Access port
    output irf_req_t req_o,
    input wire irf_rsp_t rsp_i
);
    initial begin
        req_o = '0;
    end

    // One single-word access per call, in program order, never gathered
    task automatic xfer(input logic wr, input logic [SPACE_W-1:0] sp, input logic [ADDR_W-1:0] addr,
                        input logic [DATA_W-1:0] data, input logic [STRB_W-1:0] strb, output irf_rsp_t rsp);
        req_o.valid = 1'b1;
        req_o.write = wr;
        req_o.space = sp;
        req_o.addr = addr;
        req_o.wdata = data;
        req_o.strb = strb;
        @(negedge sys_clk_i);
        rsp = rsp_i;
    endtask : xfer

    // Released address, data and strobe lines show the inverse of the last value; write and space keep the last value
    task automatic release_bus();
        req_o.valid = 1'b0;
        req_o.addr = ~req_o.addr;
        req_o.wdata = ~req_o.wdata;
        req_o.strb = ~req_o.strb;
        @(negedge sys_clk_i);
    endtask : release_bus
endmodule : irf_pe_model

/* File: bench/tb_irf_config_frame.sv */
// Self-checking testbench of the configuration register frame
`timescale 1ns/1ps
module tb_irf_config_frame
    import irf_pkg::*;
;
    localparam logic [ADDR_W-1:0] BASE = 32'h0001_0000;
    localparam logic [ADDR_W-1:0] INJ = 32'h0002_0000;
    // Arbitrary identity value
    localparam logic [DATA_W-1:0] ID_IMPL = 32'h0000_5A5A;
    logic sys_clk_i;
    logic sys_rst_i;
    irf_req_t req;
    irf_rsp_t rsp;
    logic enable;
    logic idle;
    int fails;
    int check_count;
    logic [11:0] rw_tbl [23] = '{OFS_SH_VM, OFS_SH_VM + 12'h004, OFS_SH_DOM, OFS_SH_CFG, OFS_CORE_CTRL,
        OFS_ST_BASE, OFS_ST_BASE + 12'h004, OFS_ST_CFG, OFS_VMT_BASE, OFS_VMT_CFG, OFS_VC_SEL, OFS_VC_DB,
        OFS_VC_CTRL, OFS_VM_DB, OFS_MAP_VMT_L2, OFS_MAP_VM, OFS_MAP_VST, OFS_MAP_VST_L2, OFS_MAP_VC,
        OFS_SAVE_VM, OFS_MEM_ENC_CTX, 12'hE00, 12'hEFC};
    logic [11:0] wo_tbl [6] = '{OFS_SYNC_REQ, OFS_SH_SEL, OFS_SH_RESAMPLE, OFS_CORE_SEL, OFS_ST_L2MAP, OFS_VM_SEL};
    logic [15:0] gap_tbl [5] = '{16'h0020, 16'h0048, 16'h03FC, 16'h0F00, 16'hFFFC};

    irf_config_frame #(.IMPL_ID_VALUE(ID_IMPL)) i_irf_config_frame (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .rsp_o(rsp), .enable_o(enable), .idle_o(idle));
    irf_pe_model i_irf_pe_model (.sys_clk_i(sys_clk_i), .req_o(req), .rsp_i(rsp));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic acc(input logic wr, input logic [SPACE_W-1:0] sp, input logic [ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] data, input logic [STRB_W-1:0] strb,
                       input logic hit, input logic [DATA_W-1:0] exp);
        irf_rsp_t r;
        i_irf_pe_model.xfer(wr, sp, addr, data, strb, r);
        check($sformatf("flags@%h", addr), {30'h0, r.valid, r.hit}, {30'h0, 1'b1, hit});
        check($sformatf("rdata@%h", addr), r.rdata, exp);
    endtask : acc

    task automatic wr(input logic [11:0] ofs, input logic [DATA_W-1:0] data);
        acc(1'b1, 2'h0, {BASE[31:16], 4'h0, ofs}, data, 4'hF, 1'b1, 32'h0000_0000);
    endtask : wr

    task automatic rd(input logic [11:0] ofs, input logic [DATA_W-1:0] exp);
        acc(1'b0, 2'h0, {BASE[31:16], 4'h0, ofs}, 32'h0000_0000, 4'h0, 1'b1, exp);
    endtask : rd

    task automatic pins(input logic en, input logic idl);
        check("enable_o", {31'h0, enable}, {31'h0, en});
        check("idle_o", {31'h0, idle}, {31'h0, idl});
    endtask : pins

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #200000;
        fails++;
        $display("ERROR watchdog expected done seen hang");
        tally_and_finish();
    end

    initial begin
        fails = 0;
        check_count = 0;
        sys_rst_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        rd(OFS_CTRL0, 32'h0000_0002);
        pins(1'b0, 1'b1);
        rd(OFS_ID0, 32'h0000_0001);
        rd(OFS_IMPL_ID, ID_IMPL);
        $display("test reset_values done");
        // Fill every word before reading, so aliasing between slots shows
        foreach (rw_tbl[i]) wr(rw_tbl[i], {16'hA5C3, 4'h0, rw_tbl[i]});
        foreach (rw_tbl[i]) rd(rw_tbl[i], {16'hA5C3, 4'h0, rw_tbl[i]});
        // Back-to-back write then read of one slot, the case the slot check watches
        wr(12'hE40, 32'h3C3C_0E40);
        rd(12'hE40, 32'h3C3C_0E40);
        wr(OFS_CTRL1, 32'hFFFF_FFFF);
        rd(OFS_CTRL1, 32'h0000_FFFF);
        acc(1'b1, 2'h0, BASE + 32'h0000_0084, 32'h0000_0055, 4'h1, 1'b1, 32'h0000_0000);
        rd(OFS_CTRL1, 32'h0000_FF55);
        $display("test read_write done");
        wr(OFS_ID0, 32'hFFFF_FFFE);
        rd(OFS_ID0, 32'h0000_0001);
        wr(OFS_IMPL_ID, 32'hFFFF_FFFF);
        rd(OFS_IMPL_ID, ID_IMPL);
        foreach (wo_tbl[i]) begin
            wr(wo_tbl[i], 32'hFFFF_FFFF);
            rd(wo_tbl[i], 32'h0000_0000);
        end
        $display("test access_kinds done");
        foreach (gap_tbl[i]) begin
            acc(1'b1, 2'h0, {BASE[31:16], gap_tbl[i]}, 32'hFFFF_FFFF, 4'hF, 1'b1, 32'h0000_0000);
            acc(1'b0, 2'h0, {BASE[31:16], gap_tbl[i]}, 32'h0000_0000, 4'h0, 1'b1, 32'h0000_0000);
        end
        $display("test unmapped done");
        acc(1'b1, 2'h1, BASE + 32'h0000_0084, 32'h0000_0000, 4'hF, 1'b0, 32'h0000_0000);
        acc(1'b0, 2'h1, BASE + 32'h0000_0084, 32'h0000_0000, 4'h0, 1'b0, 32'h0000_0000);
        acc(1'b1, 2'h3, BASE + 32'h0000_0084, 32'h0000_0000, 4'hF, 1'b0, 32'h0000_0000);
        acc(1'b0, 2'h0, BASE - 32'h0000_0004, 32'h0000_0000, 4'h0, 1'b0, 32'h0000_0000);
        acc(1'b0, 2'h0, 32'h0003_0000, 32'h0000_0000, 4'h0, 1'b0, 32'h0000_0000);
        acc(1'b1, 2'h0, INJ + 32'h0000_0004, 32'h1111_1111, 4'hF, 1'b1, 32'h0000_0000);
        acc(1'b0, 2'h0, INJ + 32'h0000_0004, 32'h0000_0000, 4'h0, 1'b1, 32'h0000_0000);
        rd(OFS_CTRL1, 32'h0000_FF55);
        $display("test gating done");
        wr(OFS_CTRL0, 32'h0000_0001);
        pins(1'b1, 1'b0);
        // Disable attempt lands while the transition is still running
        wr(OFS_CTRL0, 32'h0000_0000);
        i_irf_pe_model.release_bus();
        i_irf_pe_model.release_bus();
        pins(1'b1, 1'b0);
        i_irf_pe_model.release_bus();
        pins(1'b1, 1'b1);
        rd(OFS_CTRL0, 32'h0000_0003);
        $display("test enable done");
        i_irf_pe_model.release_bus();
        sys_rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        pins(1'b0, 1'b1);
        rd(OFS_CTRL1, 32'h0000_0000);
        rd(OFS_CTRL0, 32'h0000_0002);
        i_irf_pe_model.release_bus();
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule : tb_irf_config_frame
